// *** pkg/count_readout_pkg.sv ***
/*
 Constants for the prescaled decade counter chains and their nibble readout.
 Assumes a single bus clock domain; the reader recombines nibbles in software.
*/
// Contract
// - Address bit five picks chain A or B
// - Low address zero returns residue on D2, D3
// - Bit three units, bit four tens stage
// - Bits three and four pick decades zero..five
// - Route select high feeds IF to chain A
package count_readout_pkg;
    // Readout port widths
    localparam int ADDR_W = 6;
    localparam int NIB_W = 4;
    // Address fields
    localparam int CHAIN_BIT = 5;
    localparam logic [4:0] ADDR_RESIDUE = 5'h00;
    localparam logic [4:0] ADDR_UNITS = 5'h08;
    localparam logic [4:0] ADDR_TENS = 5'h10;
    localparam logic [1:0] DECADE_PREFIX = 2'h3;
    localparam int DECADE_SEL_W = 3;
    // Residue lands on the upper two data bits
    localparam int RESIDUE_LSB = 2;
    localparam int RESIDUE_W = 2;
    localparam logic [1:0] RESIDUE_MAX = 2'h3;
    localparam logic [1:0] RESIDUE_RST = 2'h0;
    // Direct-mode extra divider
    localparam logic [1:0] PREDIV_MAX = 2'h3;
    // BCD digit limits
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_RST = 4'h0;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    // Documented stage count: units, tens and six decades
    localparam int DIGITS_DEF = 8;
    // Number of pin inputs passing the synchroniser
    localparam int SYNC_W = 14;
endpackage

// *** design/decade_stage.sv ***
/*
 One BCD counter digit with ripple-style carry.
 Assumes the carry in is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ns
module decade_stage
    import count_readout_pkg::*;
(
    input wire logic clk,          // Bus clock
    input wire logic rst,          // Synchronous reset
    input wire logic ce,           // Clock enable
    input wire logic clr,          // Count clear
    input wire logic inc,          // Carry in pulse
    output logic [3:0] digit,      // Current BCD digit
    output logic carry             // Carry out, combinational
);
    logic [3:0] digit_q; // Held digit
    logic [3:0] digit_d; // Next digit

    // Carry leaves only on the nine to zero step
    assign carry = inc && (digit_q == BCD_MAX);
    assign digit = digit_q;

    // Next digit: clear beats counting so a gate restart begins at zero
    always_comb begin
        digit_d = digit_q;
        if (clr) begin
            digit_d = BCD_RST;
        end else if (carry) begin
            digit_d = BCD_RST;
        end else if (inc) begin
            digit_d = digit_q + 4'h1;
        end
    end

    // Register only
    always_ff @(posedge clk) begin
        if (rst) begin
            digit_q <= BCD_RST;
        end else if (ce) begin
            digit_q <= digit_d;
        end
    end
endmodule

// *** design/prescaled_decade_counter_readout.sv ***
/*
 Two counter chains (A, B), each a two-bit residue, units, tens and decades,
 read one nibble at a time over a six-bit address and four-bit data port.
 Assumes all pins are asynchronous to CLK; the reader keeps address stable
 while the strobe is low and does the weighting by four or sixteen itself.
*/
`timescale 1ns/1ns
module prescaled_decade_counter_readout
    import count_readout_pkg::*;
#(
    parameter int DIGITS = DIGITS_DEF // Units, tens and decade stages
) (
    input wire logic CLK,                          // Bus clock, 20 MHz
    input wire logic RST,                          // Synchronous reset, high
    input wire logic CE,                           // Clock enable
    input wire logic MAIN_IN,                      // Prescaled or direct input
    input wire logic IF_IN,                        // Intermediate-frequency input
    input wire logic DIRECT_MODE,                  // Extra divide by four active
    input wire logic CHAIN_ROUTE_SELECT,           // High: IF feeds chain A
    input wire logic GATE_A,                       // Chain A counts while high
    input wire logic GATE_B,                       // Chain B counts while high
    input wire logic COUNT_CLEAR,                  // Clears both chains
    input wire logic [ADDR_W-1:0] NIBBLE_ADDR,     // Nibble address
    input wire logic COUNT_NIBBLE_READ_STROBE_N,   // Read strobe, low active
    output logic [NIB_W-1:0] DATA_OUT,             // Data lines, driven value
    output logic DATA_OE_N                         // Low while driving data
);
    // Decades sit behind units and tens and use three select bits
    if (DIGITS < 3 || DIGITS - 2 > (1 << DECADE_SEL_W)) begin : g_bad_digits
        $error("DIGITS out of range");
    end

    // Synchroniser stages; stage one is read only by stage two
    logic [SYNC_W-1:0] s1_q; // First stage
    logic [SYNC_W-1:0] s2_q; // Second stage
    logic [SYNC_W-1:0] pins; // Packed pin inputs
    // Reset image of the pins: bit seven is the strobe, which idles high,
    // so leaving reset never looks like a read and never drives the lines
    localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(8'h80);

    assign pins = {NIBBLE_ADDR, COUNT_NIBBLE_READ_STROBE_N, COUNT_CLEAR,
                   GATE_B, GATE_A, CHAIN_ROUTE_SELECT, DIRECT_MODE, IF_IN, MAIN_IN};

    // Synchronised views
    logic main_s, if_s, direct_s, route_s, gate_a_s, gate_b_s, clear_s, rd_n_s;
    logic [ADDR_W-1:0] addr_s;
    assign main_s = s2_q[0];
    assign if_s = s2_q[1];
    assign direct_s = s2_q[2];
    assign route_s = s2_q[3];
    assign gate_a_s = s2_q[4];
    assign gate_b_s = s2_q[5];
    assign clear_s = s2_q[6];
    assign rd_n_s = s2_q[7];
    assign addr_s = s2_q[SYNC_W-1:8];

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge CLK) begin
        if (RST) begin
            s1_q <= SYNC_IDLE;
            s2_q <= SYNC_IDLE;
        end else if (CE) begin
            s1_q <= pins;
            s2_q <= s1_q;
        end
    end

    // Edge detection on the synchronised count inputs
    logic main_prev_q, main_prev_d; // Last main level
    logic if_prev_q, if_prev_d;     // Last IF level
    logic main_rise, if_rise;       // One-cycle rising edges
    // Input rate is limited to CLK/2 by the synchroniser; a trade for safety

    // Direct-mode predivider
    logic [1:0] prediv_q, prediv_d; // Extra divide-by-four state
    logic main_pulse;               // Pulse entering the chains

    // Residues and routed chain pulses
    logic [1:0] res_q [2];  // Residue per chain, index 0 = B, 1 = A
    logic [1:0] res_d [2];  // Next residue
    logic pulse [2];        // Gated count pulse per chain
    logic units_inc [2];    // Residue wrap into units

    assign main_rise = main_s && !main_prev_q;
    assign if_rise = if_s && !if_prev_q;
    // divide by four: direct mode prepends a divider ahead of the chains
    assign main_pulse = direct_s ? (main_rise && prediv_q == PREDIV_MAX) : main_rise;
    // IF to A: route select swaps chain A onto the IF input
    assign pulse[1] = gate_a_s && (route_s ? if_rise : main_pulse);
    assign pulse[0] = gate_b_s && main_pulse;

    // Next values for edge memory, predivider and residues
    always_comb begin
        main_prev_d = main_s;
        if_prev_d = if_s;
        prediv_d = prediv_q;
        if (clear_s || !direct_s) begin
            prediv_d = RESIDUE_RST;
        end else if (main_rise) begin
            prediv_d = prediv_q + 2'h1;
        end
        for (int c = 0; c < 2; c++) begin
            res_d[c] = res_q[c];
            units_inc[c] = pulse[c] && res_q[c] == RESIDUE_MAX;
            if (clear_s) begin
                res_d[c] = RESIDUE_RST;
            end else if (pulse[c]) begin
                res_d[c] = res_q[c] + 2'h1;
            end
        end
    end

    // Register only
    always_ff @(posedge CLK) begin
        if (RST) begin
            main_prev_q <= 1'b0;
            if_prev_q <= 1'b0;
            prediv_q <= RESIDUE_RST;
            res_q[0] <= RESIDUE_RST;
            res_q[1] <= RESIDUE_RST;
        end else if (CE) begin
            main_prev_q <= main_prev_d;
            if_prev_q <= if_prev_d;
            prediv_q <= prediv_d;
            res_q[0] <= res_d[0];
            res_q[1] <= res_d[1];
        end
    end

    // BCD stages: digit 0 units, 1 tens, 2.. decades from hundreds up
    logic [3:0] digit [2][DIGITS]; // Digit values per chain
    logic carry [2][DIGITS+1];     // Carry chain per chain

    for (genvar c = 0; c < 2; c++) begin : g_chain
        assign carry[c][0] = units_inc[c];
        for (genvar d = 0; d < DIGITS; d++) begin : g_digit
            decade_stage u_stage (
                .clk(CLK),
                .rst(RST),
                .ce(CE),
                .clr(clear_s),
                .inc(carry[c][d]),
                .digit(digit[c][d]),
                .carry(carry[c][d+1])
            );
        end
    end

    // Decode a five-bit nibble address to a digit index, or -1 for residue
    // and -2 for an unmapped address
    function automatic int nibble_index(input logic [4:0] a);
        int idx;
        idx = -2;
        if (a == ADDR_RESIDUE) begin
            idx = -1;
        end else if (a == ADDR_UNITS) begin
            idx = 0;
        end else if (a == ADDR_TENS) begin
            idx = 1;
        end else if (a[4:3] == DECADE_PREFIX && int'(a[2:0]) < DIGITS - 2) begin
            idx = 2 + int'(a[2:0]);
        end
        return idx;
    endfunction

    // Readout registers
    logic [NIB_W-1:0] data_q, data_d; // Data lines
    logic oe_n_q, oe_n_d;             // Output enable, low drives
    logic [NIB_W-1:0] nib;            // Selected nibble
    int sel;                          // Decoded index
    int ch;                           // Chain index

    // Nibble select from synchronised address
    always_comb begin
        nib = NIB_ZERO;
        // chain select: bit five high reads chain A
        ch = addr_s[CHAIN_BIT] ? 1 : 0;
        sel = nibble_index(addr_s[4:0]);
        if (sel == -1) begin
            // residue nibble: two divider bits on D2 and D3
            nib[RESIDUE_LSB +: RESIDUE_W] = res_q[ch];
        end else if (sel >= 0) begin
            // stage digit: units, tens or decade by address
            nib = digit[ch][sel];
        end
        // Unmapped addresses read zero
    end

    // strobe drive: data follows the address while strobe is low
    always_comb begin
        oe_n_d = rd_n_s;
        data_d = rd_n_s ? NIB_ZERO : nib;
    end

    // Register only; outputs come straight from these flops
    always_ff @(posedge CLK) begin
        if (RST) begin
            data_q <= NIB_ZERO;
            oe_n_q <= 1'b1;
        end else if (CE) begin
            data_q <= data_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign DATA_OUT = data_q;
    assign DATA_OE_N = oe_n_q;
endmodule

// *** testbench/readout_assertions.sv ***
/* Checker on the nibble readout pins of the counter block.
   Assumes CE is high whenever the strobe is active and the reader keeps the
   address stable while reading. */
`timescale 1ns/1ns
module readout_assertions
    import count_readout_pkg::*;
(
    input wire logic CLK, // Bus clock
    input wire logic RST, // Sync reset
    input wire logic GATE_A, // Chain A gate
    input wire logic GATE_B, // Chain B gate
    input wire logic COUNT_CLEAR, // Count clear
    input wire logic [ADDR_W-1:0] NIBBLE_ADDR, // Nibble address
    input wire logic COUNT_NIBBLE_READ_STROBE_N, // Read strobe, low
    input wire logic [NIB_W-1:0] DATA_OUT, // Data value
    input wire logic DATA_OE_N // Low while driving
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Pin qualifiers; four samples cover the three sync and output stages
    wire logic rd = !COUNT_NIBBLE_READ_STROBE_N; // Strobe active
    wire logic [4:0] lo = NIBBLE_ADDR[4:0]; // Nibble field
    wire logic quiet = rd && !GATE_A && !GATE_B && !COUNT_CLEAR; // Counts frozen
    AST_DRIVE_ON: assert property (rd[*4] |=> !DATA_OE_N)
        else $error("data lines not driven during read");
    AST_DRIVE_OFF: assert property ((!rd)[*4] |=> DATA_OE_N && DATA_OUT == 4'h0)
        else $error("data lines still driven after read");
    AST_HOLD: assert property ((quiet && $stable(NIBBLE_ADDR))[*8] |=> $stable(DATA_OUT))
        else $error("nibble moved while counts frozen");
    AST_RESIDUE_LOW: assert property ((rd && lo == ADDR_RESIDUE)[*4] |=> DATA_OUT[1:0] == 2'h0)
        else $error("residue read has low data bits set");
    AST_CLEARED: assert property ((rd && COUNT_CLEAR && lo == ADDR_UNITS)[*8] |=> DATA_OUT == 4'h0)
        else $error("units stage not zero under clear");
    AST_BAD_DECADE: assert property ((rd && lo[4:3] == 2'h3 && lo[2:0] > 3'h5)[*4] |=> DATA_OUT == 4'h0)
        else $error("unmapped decade code returned data");
    COV_READ: cover property (rd[*4] ##1 !DATA_OE_N);
    COV_CLEAR: cover property (rd && COUNT_CLEAR);
    COV_BAD: cover property (rd && lo == 5'h1E);
endmodule

// *** testbench/nibble_reader.sv ***
/* Processor model reading count nibbles over the parallel port.
   Assumes the bench resolves the data wire with a pull-up while undriven. */
`timescale 1ns/1ns
module nibble_reader
    import count_readout_pkg::*;
(
    input wire logic clk, // Bus clock
    input wire logic [NIB_W-1:0] data_bus, // Resolved data wire
    input wire logic oe_n, // Device drive indicator
    output logic [ADDR_W-1:0] addr, // Nibble address
    output logic rd_n // Read strobe, low
);
    initial begin
        addr = 6'h00;
        rd_n = 1'b1;
    end
    // hold until answered; a missing answer returns unknown
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [NIB_W-1:0] d);
        int k;
        @(posedge clk);
        #5;
        addr = a;
        rd_n = 1'b0;
        for (k = 0; k < 8 && oe_n !== 1'b0; k++) begin
            @(posedge clk);
        end
        repeat (5) @(posedge clk);
        d = (k < 8) ? data_bus : 4'hX;
        #5;
        rd_n = 1'b1;
        for (k = 0; k < 16 && oe_n !== 1'b1; k++) begin
            @(posedge clk);
        end
    endtask
endmodule

// *** testbench/prescaled_decade_counter_readout_tb_top.sv ***
/* Top bench: counts pulse trains on both chains and reads them back.
   Assumes the default stage count and the reader model. */
`timescale 1ns/1ns
module prescaled_decade_counter_readout_tb_top
    import count_readout_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, m_in = 1'b0, i_in = 1'b0, direct = 1'b0, route = 1'b0;
    logic gate = 1'b0, clr = 1'b0, ce = 1'b1, rd_n, oe_n;
    // Addresses that map to no stage: decade codes six and seven, stray bits
    logic [ADDR_W-1:0] bad_addr [5] = '{6'h3E, 6'h3F, 6'h1E, 6'h01, 6'h2C};
    logic [ADDR_W-1:0] addr;
    logic [NIB_W-1:0] dout;
    wire logic [NIB_W-1:0] bus = oe_n ? 4'hF : dout; // Pull-up when undriven
    int n_fail = 0, tests_run = 0, cyc = 0;
    logic [31:0] seed = 32'h367E; // Fixed start keeps runs repeatable
    initial forever #25 clk = ~clk;
    prescaled_decade_counter_readout DUT (.CLK(clk), .RST(rst), .CE(ce), .MAIN_IN(m_in),
        .IF_IN(i_in), .DIRECT_MODE(direct), .CHAIN_ROUTE_SELECT(route), .GATE_A(gate),
        .GATE_B(gate), .COUNT_CLEAR(clr), .NIBBLE_ADDR(addr),
        .COUNT_NIBBLE_READ_STROBE_N(rd_n), .DATA_OUT(dout), .DATA_OE_N(oe_n));
    nibble_reader rdr (.clk(clk), .data_bus(bus), .oe_n(oe_n), .addr(addr), .rd_n(rd_n));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic conclude();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input int got, input int exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // Unknown data turns into an impossible value so totals mismatch
    task automatic nib(input logic [ADDR_W-1:0] a, output int v);
        logic [NIB_W-1:0] d;
        rdr.rd(a, d);
        v = (^d === 1'bX) ? -1 : int'(d);
    endtask
    // Residue, then units, tens and six decades
    task automatic chain(input logic c, output int r, output int v);
        int d, w, k;
        nib({c, 5'h00}, r);
        r = r >> 2;
        nib({c, 5'h08}, v);
        nib({c, 5'h10}, d);
        v += 10 * d;
        w = 100;
        for (k = 0; k < 6; k++) begin
            nib({c, 2'h3, k[2:0]}, d);
            v += w * d;
            w *= 10;
        end
    endtask
    // Clear with a units read under it, then n1 IF and n2 main edges
    task automatic count(input int n1, input int n2);
        int v;
        @(posedge clk);
        #5 clr = 1'b1;
        nib(6'h28, v);
        chk(v, 0);
        #5 clr = 1'b0;
        gate = 1'b1;
        repeat (4) @(posedge clk);
        for (int k = 0; k < n1 + n2; k++) begin
            #5 if (k < n1) i_in = 1'b1; else m_in = 1'b1;
            repeat (3) @(posedge clk);
            #5 i_in = 1'b0;
            m_in = 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (5) @(posedge clk);
        #5 gate = 1'b0;
    endtask
    initial begin
        int n, n2, r, v;
        repeat (2) @(posedge clk);
        #5 rst = 1'b0;
        for (int k = 0; k < 4; k++) begin
            seed = nxt(seed);
            n = (k == 0) ? 3 : (k == 1) ? 41 : 1 + int'(seed[8:0]);
            count(0, n);
            chain(1'b1, r, v);
            chk(r + 4 * v, n);
            chk(r, n % 4);
            chain(1'b0, r, v);
            chk(r + 4 * v, n);
        end
        $display("test prescaled done");
        #5 direct = 1'b1;
        seed = nxt(seed);
        n = 64 + int'(seed[7:0]);
        count(0, n);
        chain(1'b0, r, v);
        chk(16 * v + 4 * r, n - n % 4);
        #5 direct = 1'b0;
        $display("test direct done");
        route = 1'b1;
        seed = nxt(seed);
        n = 1 + int'(seed[5:0]);
        n2 = 1 + int'(seed[13:8]);
        count(n, n2);
        chain(1'b1, r, v);
        chk(r + 4 * v, n);
        chain(1'b0, r, v);
        chk(r + 4 * v, n2);
        $display("test route done");
        for (int i = 0; i < 5; i++) begin
            nib(bad_addr[i], v);
            chk(v, 0);
        end
        $display("test unmapped done");
        // Clock enable low: edges under an open gate must be lost
        @(posedge clk);
        #5 ce = 1'b0;
        gate = 1'b1;
        for (int k = 0; k < 8; k++) begin
            repeat (3) @(posedge clk);
            #5 m_in = ~m_in;
        end
        repeat (3) @(posedge clk);
        #5 gate = 1'b0;
        repeat (3) @(posedge clk);
        #5 ce = 1'b1;
        chain(1'b0, r, v);
        chk(r + 4 * v, n2);
        $display("test freeze done");
        conclude();
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            conclude();
        end
    end
endmodule
bind prescaled_decade_counter_readout readout_assertions chk_i (.CLK(CLK), .RST(RST),
    .GATE_A(GATE_A), .GATE_B(GATE_B), .COUNT_CLEAR(COUNT_CLEAR), .NIBBLE_ADDR(NIBBLE_ADDR),
    .COUNT_NIBBLE_READ_STROBE_N(COUNT_NIBBLE_READ_STROBE_N), .DATA_OUT(DATA_OUT),
    .DATA_OE_N(DATA_OE_N));
